// >>> design/spim_pkg.sv
// constants, register map and carrier types of the master spi port
`default_nettype none
package spim_pkg;
   // register byte offsets on apb
   localparam logic [7:0] data_off = 8'h00;
   localparam logic [7:0] status_off = 8'h04;
   localparam logic [7:0] control_off = 8'h08;
   localparam logic [7:0] format_off = 8'h0c;
   localparam logic [7:0] baud_off = 8'h10;
   // status bit positions
   localparam int rx_done_pos = 7;
   localparam int tx_done_pos = 6;
   localparam int tx_empty_pos = 5;
   // control bit positions
   localparam int rx_irq_en_pos = 7;
   localparam int tx_irq_en_pos = 6;
   localparam int tx_empty_irq_en_pos = 5;
   localparam int rx_en_pos = 4;
   localparam int tx_en_pos = 3;
   // format bit positions
   localparam int mode_hi_pos = 7;
   localparam int mode_lo_pos = 6;
   localparam int order_pos = 2;
   localparam int phase_pos = 1;
   localparam int polarity_pos = 0;
   // reset values, frame length and divisor width
   localparam logic [7:0] control_rst = 8'h00;
   localparam logic [7:0] format_rst = 8'h06;
   localparam logic [11:0] baud_rst = 12'h000;
   localparam int frame_bits = 8;
   localparam int baud_w = 12;

   typedef struct packed {
      logic polarity;
      logic phase;
      logic lsb_first;
   } spi_fmt_s;

   typedef struct packed {
      logic sclk;
      logic sclk_oe;
      logic mosi;
      logic mosi_oe;
   } spi_pins_s;
endpackage : spim_pkg
`default_nettype wire

// >>> design/spim_shifter.sv
// one 8-bit full duplex spi frame engine with baud divider
`default_nettype none
module spim_shifter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [7:0] tx_byte,
   input wire logic [11:0] baud_divisor,
   input wire spim_pkg::spi_fmt_s fmt,
   input wire logic miso_sync,
   output logic busy,
   output logic done,
   output logic [7:0] rx_byte,
   output logic sclk,
   output logic mosi
);
   logic [11:0] div_r;
   logic [3:0] edge_r;
   logic [7:0] sh_r;
   logic [7:0] in_r;
   logic tick;
   logic lead;
   logic last;
   logic in_bit;

   assign tick = busy && (div_r == 12'h000);
   assign lead = ~edge_r[0];
   assign last = (edge_r == 4'hf);
   assign in_bit = miso_sync;

   // divider and edge counter; each tick is half an spi clock: f/(2(n+1))
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 12'h000;
         edge_r <= 4'h0;
         busy <= 1'b0;
      end else if (start && !busy) begin
         div_r <= baud_divisor;
         edge_r <= 4'h0;
         busy <= 1'b1;
      end else if (busy) begin
         if (tick) begin
            div_r <= baud_divisor;
            edge_r <= edge_r + 4'h1;
            if (last) begin
               busy <= 1'b0;
            end
         end else begin
            div_r <= div_r - 12'h001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done <= 1'b0;
      end else begin
         done <= tick && last;
      end
   end

   // clock toggles on each tick, idles at polarity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk <= 1'b0;
      end else if (!busy) begin
         sclk <= fmt.polarity;
      end else if (tick) begin
         sclk <= last ? fmt.polarity : ~sclk;
      end
   end

   // sample on leading edge for phase 0, trailing for phase 1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh_r <= 8'h00;
         in_r <= 8'h00;
         mosi <= 1'b1;
      end else if (start && !busy) begin
         sh_r <= tx_byte;
         mosi <= fmt.lsb_first ? tx_byte[0] : tx_byte[7];
      end else if (tick) begin
         if (lead ^ fmt.phase) begin
            // sample edge
            in_r <= fmt.lsb_first ? {in_bit, in_r[7:1]} : {in_r[6:0], in_bit};
         end else begin
            // setup edge; phase 1 drives the first bit on the first edge
            if (!(fmt.phase && edge_r == 4'h0)) begin
               sh_r <= fmt.lsb_first ? {1'b0, sh_r[7:1]} : {sh_r[6:0], 1'b0};
            end
            if (fmt.phase && edge_r == 4'h0) begin
               mosi <= fmt.lsb_first ? sh_r[0] : sh_r[7];
            end else if (!last) begin
               mosi <= fmt.lsb_first ? sh_r[1] : sh_r[6];
            end
         end
      end
   end

   assign rx_byte = in_r;
endmodule : spim_shifter
`default_nettype wire

// >>> design/spim_port.sv
// apb master-only spi port with buffered transmit and two-level receive
// What this block does
// - baud divisor resets to zero.
// - transmitter enable gives the output pin to serial data.
// - receiver enable, with the transmitter also enabled, takes the input pin as serial input.
// - clock pin carries transfer clock when transmitter enabled and clock pin direction is set.
// - every transfer starts with a data register write.
// - written byte waits in buffer, moves to shifter when free.
// - on receive overflow the newest byte is dropped.
// - framing, overrun and parity flags always read zero.
// - receive-complete at bit 7 is high while unread data is held.
// - disabling the receiver flushes the receive buffer.
// - transmit-complete at bit 6 sets when shifter and buffer are empty.
// - transmit-complete clears on interrupt service or written one.
// - buffer-empty at bit 5 is one when buffer free, set at reset.
// - receive interrupt needs enable bit 7, global flag and flag.
// - transmit interrupt needs enable bit 6, global flag and flag.
// - spi master mode only when both mode select bits are one.
// - eight bits per frame, order chosen by data-order bit.
// - polarity and phase select spi modes 0 to 3.
// - clock rate is system clock over twice divisor plus one.
//
// Chosen here: the APB register port and the register addresses.
`default_nettype none
module spim_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic global_irq_enable,
   input wire logic tx_done_irq_ack,
   input wire logic clock_pin_direction,
   input wire logic serial_in_pin,
   output spim_pkg::spi_pins_s pins,
   output logic rx_done_irq,
   output logic tx_done_irq,
   output logic tx_empty_irq,
   output logic serial_in_used
);
   logic [7:0] control_r;
   logic [7:0] format_r;
   logic [11:0] baud_divisor_r;
   logic [7:0] tx_buf_r;
   logic tx_full_r;
   logic [7:0] rx_buf0_r;
   logic [7:0] rx_buf1_r;
   logic [1:0] rx_cnt_r;
   logic tx_done_r;
   logic miso_s1_r;
   logic miso_s2_r;
   logic wr;
   logic rd;
   logic data_wr;
   logic data_rd;
   logic start;
   logic busy;
   logic done;
   logic [7:0] rx_byte;
   logic sclk;
   logic mosi;
   logic tx_en;
   logic rx_en;
   logic spi_mode;
   logic addr_ok;
   spim_pkg::spi_fmt_s fmt;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign addr_ok = (paddr == spim_pkg::data_off) || (paddr == spim_pkg::status_off)
      || (paddr == spim_pkg::control_off) || (paddr == spim_pkg::format_off)
      || (paddr == spim_pkg::baud_off);
   assign pslverr = psel && penable && !addr_ok;
   assign data_wr = wr && (paddr == spim_pkg::data_off);
   assign data_rd = rd && (paddr == spim_pkg::data_off);

   assign tx_en = control_r[spim_pkg::tx_en_pos];
   assign rx_en = control_r[spim_pkg::rx_en_pos] && tx_en;
   assign spi_mode = format_r[spim_pkg::mode_hi_pos] && format_r[spim_pkg::mode_lo_pos];
   assign fmt.polarity = format_r[spim_pkg::polarity_pos];
   assign fmt.phase = format_r[spim_pkg::phase_pos];
   assign fmt.lsb_first = format_r[spim_pkg::order_pos];

   // frame starts only in spi mode with the transmitter on
   assign start = tx_full_r && !busy && tx_en && spi_mode;

   // pin input passes two flops before the shifter sees it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miso_s1_r <= 1'b0;
         miso_s2_r <= 1'b0;
      end else begin
         miso_s1_r <= serial_in_pin;
         miso_s2_r <= miso_s1_r;
      end
   end

   spim_shifter u_shifter (
      .pclk(pclk),
      .presetn(presetn),
      .start(start),
      .tx_byte(tx_buf_r),
      .baud_divisor(baud_divisor_r),
      .fmt(fmt),
      .miso_sync(miso_s2_r),
      .busy(busy),
      .done(done),
      .rx_byte(rx_byte),
      .sclk(sclk),
      .mosi(mosi)
   );

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_r <= spim_pkg::control_rst;
         format_r <= spim_pkg::format_rst;
         baud_divisor_r <= spim_pkg::baud_rst;
      end else if (wr) begin
         if (paddr == spim_pkg::control_off) begin
            control_r <= {pwdata[7:3], 3'b000};
         end else if (paddr == spim_pkg::format_off) begin
            format_r <= {pwdata[7:6], 3'b000, pwdata[2:0]};
         end else if (paddr == spim_pkg::baud_off) begin
            baud_divisor_r <= pwdata[11:0];
         end
      end
   end

   // transmit buffer; a write while full is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_buf_r <= 8'h00;
         tx_full_r <= 1'b0;
      end else if (data_wr && !tx_full_r && tx_en) begin
         tx_buf_r <= pwdata[7:0];
         tx_full_r <= 1'b1;
      end else if (start) begin
         tx_full_r <= 1'b0;
      end
   end

   // two-level receive queue; third byte lost while both held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_buf0_r <= 8'h00;
         rx_buf1_r <= 8'h00;
         rx_cnt_r <= 2'd0;
      end else if (!rx_en) begin
         rx_cnt_r <= 2'd0;
      end else begin
         case ({done, data_rd && (rx_cnt_r != 2'd0)})
            2'b10: begin
               if (rx_cnt_r == 2'd0) begin
                  rx_buf0_r <= rx_byte;
                  rx_cnt_r <= 2'd1;
               end else if (rx_cnt_r == 2'd1) begin
                  rx_buf1_r <= rx_byte;
                  rx_cnt_r <= 2'd2;
               end
               // full: newest byte dropped
            end
            2'b01: begin
               rx_buf0_r <= rx_buf1_r;
               rx_cnt_r <= rx_cnt_r - 2'd1;
            end
            2'b11: begin
               if (rx_cnt_r == 2'd1) begin
                  rx_buf0_r <= rx_byte;
               end else begin
                  rx_buf0_r <= rx_buf1_r;
                  rx_buf1_r <= rx_byte;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_done_r <= 1'b0;
      end else if (done && !tx_full_r) begin
         tx_done_r <= 1'b1;
      end else if (tx_done_irq_ack || (wr && paddr == spim_pkg::status_off
            && pwdata[spim_pkg::tx_done_pos])) begin
         tx_done_r <= 1'b0;
      end
   end

   // read mux; error flags bits 4:2 read zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (paddr == spim_pkg::data_off) begin
            prdata[7:0] <= rx_buf0_r;
         end else if (paddr == spim_pkg::status_off) begin
            prdata[spim_pkg::rx_done_pos] <= rx_cnt_r != 2'd0;
            prdata[spim_pkg::tx_done_pos] <= tx_done_r;
            prdata[spim_pkg::tx_empty_pos] <= !tx_full_r;
            prdata[4:0] <= 5'b0_0000;
         end else if (paddr == spim_pkg::control_off) begin
            prdata[7:0] <= control_r;
         end else if (paddr == spim_pkg::format_off) begin
            prdata[7:0] <= format_r;
         end else if (paddr == spim_pkg::baud_off) begin
            prdata[11:0] <= baud_divisor_r;
         end
      end
   end

   // pin ownership
   assign pins.mosi = tx_en ? mosi : 1'b1;
   assign pins.mosi_oe = tx_en;
   assign pins.sclk = sclk;
   assign pins.sclk_oe = tx_en && clock_pin_direction;
   assign serial_in_used = rx_en;

   // level requests
   assign rx_done_irq = control_r[spim_pkg::rx_irq_en_pos] && global_irq_enable
      && (rx_cnt_r != 2'd0);
   assign tx_done_irq = control_r[spim_pkg::tx_irq_en_pos] && global_irq_enable
      && tx_done_r;
   assign tx_empty_irq = control_r[spim_pkg::tx_empty_irq_en_pos] && global_irq_enable
      && !tx_full_r;
endmodule : spim_port
`default_nettype wire

// >>> testbench/spim_port_monitor.sv
// port assertions of the master spi port
`default_nettype none
module spim_port_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic global_irq_enable,
   input wire logic tx_done_irq_ack,
   input wire logic clock_pin_direction,
   input wire spim_pkg::spi_pins_s pins,
   input wire logic rx_done_irq,
   input wire logic tx_done_irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic [11:0] baud_r;
   int gap_r;
   wire logic acc = psel && penable;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) baud_r <= 12'h000;
      else if (acc && pwrite && paddr == spim_pkg::baud_off) baud_r <= pwdata[11:0];
   end
   // cycles since the last clock pin change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gap_r <= 0;
      else gap_r <= $changed(pins.sclk) ? 0 : gap_r + 1;
   end
   a_sclk_rate: assert property ($changed(pins.sclk) |-> gap_r >= baud_r)
      else $error("sclk edge early");
   a_rx_irq_gate: assert property (rx_done_irq |-> global_irq_enable)
      else $error("rx irq ungated");
   a_tx_irq_gate: assert property (tx_done_irq |-> global_irq_enable)
      else $error("tx irq ungated");
   a_irq_level_holds: assert property (tx_done_irq && !tx_done_irq_ack && !(acc && pwrite)
      |=> tx_done_irq || !global_irq_enable) else $error("tx irq dropped");
   a_ack_clears: assert property (tx_done_irq_ack |=> !tx_done_irq)
      else $error("ack kept irq");
   a_mosi_idle: assert property (!pins.mosi_oe |-> pins.mosi)
      else $error("mosi not idle");
   a_clock_pin: assert property (pins.sclk_oe |-> clock_pin_direction && pins.mosi_oe)
      else $error("clock pin drive");
   a_flags_zero: assert property (acc && !pwrite && paddr == spim_pkg::status_off
      |-> prdata[4:0] == 5'h00) else $error("status low bits");
endmodule // spim_port_monitor
bind spim_port spim_port_monitor spim_port_monitor_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .global_irq_enable(global_irq_enable), .tx_done_irq_ack(tx_done_irq_ack),
   .clock_pin_direction(clock_pin_direction), .pins(pins), .rx_done_irq(rx_done_irq),
   .tx_done_irq(tx_done_irq));
`default_nettype wire

// >>> testbench/spi_slave_model.sv
// behavioural spi slave on the far side of the port
`default_nettype none
module spi_slave_model (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic lsb_first,
   input wire logic load,
   input wire logic [7:0] base,
   output logic miso,
   output logic [7:0] got,
   output logic got_stb
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] tx, rx, nfr;
   int cnt;
   function automatic logic pick(input logic [7:0] v, input int p);
      return lsb_first ? v[p] : v[7 - p];
   endfunction
   initial begin
      miso = 1'b1;
      got_stb = 1'b0;
      cnt = 0;
   end
   // no select line, so load marks where the first frame begins
   always @(posedge load) begin
      nfr = 8'h00;
      cnt = 0;
      tx = base;
      miso = pick(base, 0);
   end
   always @(sclk) begin
      if (sclk == (cpol ~^ cpha)) begin
         rx[lsb_first ? cnt : 7 - cnt] = mosi;
         cnt++;
         if (cnt == 8) begin
            got = rx;
            got_stb = 1'b1;
            cnt = 0;
            nfr++;
            tx = base ^ nfr;
            miso = pick(tx, 0);
            #1 got_stb = 1'b0;
         end
      end else if (cnt > 0) miso = pick(tx, cnt);
   end
endmodule // spi_slave_model
`default_nettype wire

// >>> testbench/spim_port_tb.sv
// self-checking bench of the master spi port
`default_nettype none
module spim_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int baud = 2;
   localparam logic [7:0] st = spim_pkg::status_off, dat = spim_pkg::data_off;
   localparam logic [7:0] ctl = spim_pkg::control_off;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic global_en = 0, ack = 0, cpol = 0, cpha = 0, lsb = 0, load = 0;
   logic [7:0] paddr = 8'h00, base = 8'h00, got;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdata, seed = 32'h0000_3719;
   logic pready, pslverr, rx_irq, tx_irq, empty_irq, in_used, miso, got_stb;
   spim_pkg::spi_pins_s pins;
   logic [24:0] notes[$];
   logic [7:0] sent[$];
   int num_errors = 0, comparisons = 0, cycles = 0;
   always #10 pclk = ~pclk;
   spim_port spim_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .global_irq_enable(global_en), .tx_done_irq_ack(ack),
      .clock_pin_direction(1'b1), .serial_in_pin(miso), .pins(pins), .rx_done_irq(rx_irq),
      .tx_done_irq(tx_irq), .tx_empty_irq(empty_irq), .serial_in_used(in_used));
   spi_slave_model spi_slave_model_inst (.sclk(pins.sclk), .mosi(pins.mosi), .cpol(cpol),
      .cpha(cpha), .lsb_first(lsb), .load(load), .base(base), .miso(miso), .got(got),
      .got_stb(got_stb));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   // note first, so the watcher finds it when the access completes
   task automatic rd(input logic [7:0] a, input logic [11:0] e, input logic [11:0] m,
      input logic err);
      notes.push_back({err, m, e});
      xfer(1'b0, a, 32'h0000_0000);
   endtask
   task automatic wait_bit(input int p, input logic v);
      int n;
      n = 0;
      do begin
         xfer(1'b0, st, 32'h0000_0000);
         n++;
      end while (rdata[p] !== v && n < 300);
      check(rdata[p] === v, "status wait");
   endtask
   task automatic chk_reg(input logic [24:0] n);
      check((prdata[11:0] & n[23:12]) === n[11:0] && pslverr === n[24], "register read");
   endtask
   task automatic chk_byte(input logic [7:0] g);
      check(sent.size() > 0 && g === sent.pop_front(), "mosi byte");
   endtask
   task automatic chk_lvl(input logic v, input logic e);
      check(v === e, "output level");
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         end_sim;
      end
      if (psel && penable && pready && !pwrite && notes.size() > 0) chk_reg(notes.pop_front());
   end
   always @(posedge got_stb) chk_byte(got);
   initial begin
      logic [2:0] f;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(st, 12'h020, 12'h0ff, 1'b0);
      rd(ctl, 12'h000, 12'h0ff, 1'b0);
      rd(spim_pkg::format_off, 12'h006, 12'h0ff, 1'b0);
      rd(spim_pkg::baud_off, 12'h000, 12'hfff, 1'b0);
      rd(8'h14, 12'h000, 12'h000, 1'b1);
      $display("reset test done");
      wr(spim_pkg::format_off, 8'hc0);
      wr(ctl, 8'h18);
      wr(spim_pkg::baud_off, baud);
      chk_lvl(pins.mosi_oe, 1'b1);
      chk_lvl(in_used, 1'b1);
      chk_lvl(pins.sclk_oe, 1'b1);
      for (int m = 0; m < 4; m++) begin
         f = {m[1] ^ m[0], m[0], m[1]};
         cpol <= f[0];
         cpha <= f[1];
         lsb <= f[2];
         seed = lfsr(seed);
         base <= seed[15:8];
         wr(spim_pkg::format_off, 8'hc0 | f);
         load <= 1'b1;
         @(posedge pclk);
         load <= 1'b0;
         sent.push_back(seed[7:0]);
         wr(dat, seed[7:0]);
         wait_bit(spim_pkg::rx_done_pos, 1'b1);
         rd(dat, base, 12'h0ff, 1'b0);
      end
      $display("mode test done");
      seed = lfsr(seed);
      base <= seed[7:0];
      // mode frames left transmit-complete set; clear it before new writes
      wr(st, 32'h0000_0040);
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         wait_bit(spim_pkg::tx_empty_pos, 1'b1);
         seed = lfsr(seed);
         sent.push_back(seed[7:0]);
         wr(dat, seed[7:0]);
         if (i == 1) begin
            rd(st, 12'h000, 12'h060, 1'b0);
            wr(dat, 8'h5a);
         end
      end
      wait_bit(spim_pkg::tx_done_pos, 1'b1);
      rd(st, 12'h0e0, 12'h0ff, 1'b0);
      rd(dat, base, 12'h0ff, 1'b0);
      rd(dat, base ^ 8'h01, 12'h0ff, 1'b0);
      rd(st, 12'h000, 12'h080, 1'b0);
      $display("queue test done");
      wr(ctl, 8'hd8);
      global_en <= 1'b1;
      @(posedge pclk);
      chk_lvl(tx_irq, 1'b1);
      chk_lvl(empty_irq, 1'b0);
      ack <= 1'b1;
      @(posedge pclk);
      ack <= 1'b0;
      @(posedge pclk);
      chk_lvl(tx_irq, 1'b0);
      sent.push_back(8'h3c);
      wr(dat, 8'h3c);
      wait_bit(spim_pkg::rx_done_pos, 1'b1);
      chk_lvl(rx_irq, 1'b1);
      global_en <= 1'b0;
      @(posedge pclk);
      chk_lvl(rx_irq, 1'b0);
      chk_lvl(tx_irq, 1'b0);
      rd(st, 12'h040, 12'h040, 1'b0);
      wr(st, 8'h40);
      rd(st, 12'h080, 12'h0c0, 1'b0);
      wr(ctl, 8'h08);
      rd(st, 12'h000, 12'h080, 1'b0);
      chk_lvl(in_used, 1'b0);
      wr(ctl, 8'h00);
      chk_lvl(pins.mosi_oe, 1'b0);
      chk_lvl(pins.mosi, 1'b1);
      $display("irq test done");
      end_sim;
   end
endmodule // spim_port_tb
`default_nettype wire
